// ### verilog/sdl_pkg.sv
// Package: constants and carriers for the single-wire debug link engine
package sdl_pkg;

	// ----------------------------------------------------------------
	// Bit timing, in debug clock ticks
	// ----------------------------------------------------------------
	localparam logic [7:0] BIT_TICKS = 8'h10;          // Nominal bit period
	localparam logic [7:0] RX_SAMPLE_TICKS = 8'h0a;    // Host bit sampled here
	localparam logic [7:0] TX1_PULSE_TICK = 8'h07;     // Speed-up pulse for a one
	localparam logic [7:0] TX0_LOW_TICKS = 8'h0d;      // Low time for a zero
	localparam logic [9:0] TIMEOUT_TICKS = 10'h200;    // Gap between host edges
	localparam logic [7:0] SYNC_DETECT_TICKS = 8'h80;  // Low time that means probe
	localparam logic [7:0] SYNC_DELAY_TICKS = 8'h10;   // Wait after host release
	localparam logic [7:0] SYNC_LOW_TICKS = 8'h80;     // Low time of the answer

	// ----------------------------------------------------------------
	// Framing
	// ----------------------------------------------------------------
	localparam int CMD_W = 8;                          // Command and data width
	localparam int FIFO_DEPTH = 4;                     // Reply byte buffer depth
	localparam int ACTIVE_GROUP_BIT = 7;               // Zero in halted-only codes

	// Byte handed to the command decoder
	typedef struct packed {
		logic first;                                   // Command code byte
		logic [CMD_W-1:0] data;
	} sdl_rx_byte_t;

endpackage

// ### verilog/sdl_fifo.sv
// Small synchronous FIFO holding reply bytes for the debug link
`timescale 1ns/10ps
module sdl_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr, next_wptr;
	logic [AW-1:0] rptr, next_rptr;
	logic [AW:0] count, next_count;
	logic not_full, next_not_full;
	logic push, pop;

	// ----------------------------------------------------------------
	// Pointer and level update
	// ----------------------------------------------------------------
	// Full is kept as a flop so the upstream ready has no logic behind it
	always_comb begin
		push = in_valid && not_full;
		pop = out_ready && (count != '0);
		next_wptr = push ? wptr + 1'b1 : wptr;
		next_rptr = pop ? rptr + 1'b1 : rptr;
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
		next_not_full = (next_count != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			not_full <= 1'b1;
		end else begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			count <= next_count;
			not_full <= next_not_full;
		end
	end

	// Storage has no reset; only written entries are ever read
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wptr] <= in_data;
		end
	end

	assign in_ready = not_full;
	assign out_valid = (count != '0);
	assign out_data = mem[rptr];

endmodule

// ### verilog/sdl_link.sv
// Target-side serial engine of the single-wire debug link
//
// Functional notes
// [RL1] Halted-only command codes refused while CPU runs
// [RL2] Memory and status commands accepted at any time
// [RL3] No memory map use, no shared peripherals
// [RL4] Wire level during reset picks start mode
// [RL5] Host starts every bit with falling edge
// [RL6] MSB first, nominal sixteen ticks per bit
// [RL7] Timeout after 512 ticks between host edges
// [RL8] Timed-out command abandoned, nothing delivered
// [RL9] Select bit picks bus or alternate clock
// [RL10] Bit start seen zero to one tick late
// [RL11] Host bit sampled ten ticks after start
// [RL12] Wire left undriven during host bits
// [RL13] Host low pulse at least two ticks
// [RL14] Target one: high pulse at tick seven
// [RL15] Host samples reply about ten ticks in
// [RL16] Target zero: low thirteen ticks, pulse, release
// [RL17] Pseudo-open-drain wire with internal pull-up
// [RL18] Pulled-up wire at reset selects application
// [RL19] Link usable without a prior reset
// [RL20] Rate probe answered with timed pulse
// [RL21] Probe request: long host low, pulse, release
// [RL22] Probe answer: wait high, 16, low 128, pulse
// [RL23] Commands open with 8-bit code, MSB first
// [RL24] Host waits sixteen ticks in delay slots
// [RL25] Wire synchronised in two flops before edges
`timescale 1ns/10ps
module sdl_link (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic debug_clock_source_select,
	input wire logic alt_tick,
	input wire logic debug_wire_pin_in,
	output logic debug_wire_pin_out,
	output logic debug_wire_pin_oe,
	output logic pull_up_en,
	input wire logic sys_reset_n,
	output logic start_halted,
	input wire logic cpu_halted,
	input wire logic cmd_end,
	output logic rx_valid,
	output sdl_pkg::sdl_rx_byte_t rx_byte,
	output logic cmd_rejected,
	output logic cmd_abort,
	input wire logic tx_valid,
	input wire logic [sdl_pkg::CMD_W-1:0] tx_data,
	output logic tx_ready
);
	import sdl_pkg::*;

	typedef enum {
		ST_IDLE,
		ST_RX,
		ST_TX,
		ST_SYNC_WAIT_HIGH,
		ST_SYNC_DELAY,
		ST_SYNC_LOW,
		ST_SYNC_PULSE
	} sdl_state_t;

	// ----------------------------------------------------------------
	// Pin synchronisers and debug clock tick
	// ----------------------------------------------------------------
	logic wire_m, wire_s, wire_d, rst_m, rst_s;
	logic tick, fall;

	// Two flops per pin; only the second stage and beyond feed logic
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wire_m <= 1'b1;
			wire_s <= 1'b1; // RL25
			wire_d <= 1'b1;
			rst_m <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			wire_m <= debug_wire_pin_in;
			wire_s <= wire_m; // RL25
			wire_d <= wire_s;
			rst_m <= sys_reset_n;
			rst_s <= rst_m;
		end
	end

	// Bus clock gives a tick every cycle; alternate source is a same-domain enable
	assign tick = debug_clock_source_select ? alt_tick : 1'b1; // RL9
	// Edge found up to one cycle after the pin moved, plus synchroniser lag
	assign fall = wire_d && !wire_s; // RL10

	// ----------------------------------------------------------------
	// Reply byte buffer
	// ----------------------------------------------------------------
	logic fifo_valid, fifo_pop;
	logic [CMD_W-1:0] fifo_data;

	sdl_fifo #(
		.W(CMD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.arst_n(arst_n),
		.in_valid(tx_valid),
		.in_data(tx_data),
		.in_ready(tx_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(fifo_pop)
	);

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	sdl_state_t state, next_state;
	logic [7:0] cnt, next_cnt;
	logic [7:0] low_cnt, next_low_cnt;
	logic [9:0] tmo, next_tmo;
	logic [CMD_W-1:0] shreg, next_shreg;
	logic [2:0] bit_idx, next_bit_idx;
	logic in_cmd, next_in_cmd;
	logic tx_active, next_tx_active;
	logic tx_bit, next_tx_bit;
	logic next_oe, next_out;
	logic next_rx_valid, next_rejected, next_abort, next_start_halted;
	sdl_rx_byte_t next_rx_byte;
	logic busy, start_tx, start_tx0, start_tx1, timeout_hit;
	logic [CMD_W-1:0] rx_full;
	logic [7:0] cnt_inc;

	// A byte or a command is open between host edges; only then can it time out
	assign busy = (bit_idx != 3'h0) || in_cmd;
	assign start_tx = (state == ST_IDLE) && fall && (tx_active || (bit_idx == 3'h0 && fifo_valid));
	assign start_tx0 = start_tx && !(tx_active ? shreg[CMD_W-1] : fifo_data[CMD_W-1]);
	assign start_tx1 = start_tx && !start_tx0;
	assign timeout_hit = (state == ST_IDLE) && busy && tick && !fall
		&& (tmo == TIMEOUT_TICKS - 10'h1);
	assign rx_full = {shreg[CMD_W-2:0], wire_s};
	assign cnt_inc = tick ? cnt + 8'h01 : cnt;
	// Reply bytes are only taken at a byte boundary so host bytes never mix in
	assign fifo_pop = (state == ST_IDLE) && fall && !tx_active && (bit_idx == 3'h0)
		&& fifo_valid;

	// Next-state logic for the whole engine
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_low_cnt = low_cnt;
		next_tmo = tmo;
		next_shreg = shreg;
		next_bit_idx = bit_idx;
		next_in_cmd = in_cmd;
		next_tx_active = tx_active;
		next_tx_bit = tx_bit;
		next_oe = 1'b0;
		next_out = 1'b0;
		next_rx_valid = 1'b0;
		next_rx_byte = rx_byte;
		next_rejected = 1'b0;
		next_abort = 1'b0;
		// Pulled-up wire while reset is held picks the application start
		next_start_halted = rst_s ? start_halted : !wire_s; // RL4 RL18
		if (cmd_end) begin
			next_in_cmd = 1'b0;
		end
		if (tick && busy) begin
			next_tmo = tmo + 10'h001; // RL7
		end
		case (state)
			ST_IDLE: begin
				// Engine runs from power-up; no system reset is needed to talk
				next_low_cnt = wire_s ? 8'h00 : low_cnt; // RL19
				if (!wire_s && tick && low_cnt != SYNC_DETECT_TICKS) begin
					next_low_cnt = low_cnt + 8'h01;
				end
				if (fall) begin
					// Target never starts a bit; everything waits on the host edge
					next_tmo = 10'h000; // RL5
					next_cnt = 8'h00;
					if (start_tx) begin
						next_state = ST_TX;
						next_tx_bit = tx_active ? shreg[CMD_W-1] : fifo_data[CMD_W-1]; // RL6
						next_shreg = {(tx_active ? shreg[CMD_W-2:0] : fifo_data[CMD_W-2:0]), 1'b0};
						next_tx_active = 1'b1;
						next_oe = start_tx0;
					end else begin
						next_state = ST_RX;
					end
				end else if (timeout_hit) begin
					// Drop the partial byte and command; nothing reaches the decoder
					next_bit_idx = 3'h0; // RL7 RL8
					next_in_cmd = 1'b0; // RL8
					next_tx_active = 1'b0;
					next_tmo = 10'h000;
					next_abort = 1'b1;
				end else if (low_cnt == SYNC_DETECT_TICKS) begin
					// Far longer than any bit low, so it can only be a rate probe
					next_state = ST_SYNC_WAIT_HIGH; // RL20 RL21
					next_bit_idx = 3'h0;
					next_in_cmd = 1'b0;
					next_tx_active = 1'b0;
					next_abort = busy;
				end
			end
			ST_RX: begin
				// Wire stays released for the whole host bit
				next_oe = 1'b0; // RL12
				if (tick) begin
					if (cnt == RX_SAMPLE_TICKS - 8'h01) begin
						next_state = ST_IDLE; // RL11
						next_shreg = rx_full; // RL6
						next_bit_idx = bit_idx + 3'h1;
						next_low_cnt = 8'h00;
						if (bit_idx == 3'h7) begin
							next_rx_byte.first = !in_cmd; // RL23
							next_rx_byte.data = rx_full;
							if (!in_cmd && !rx_full[ACTIVE_GROUP_BIT] && !cpu_halted) begin
								next_rejected = 1'b1; // RL1
							end else begin
								// Non-intrusive codes pass whether or not the CPU runs
								next_rx_valid = 1'b1; // RL2
								next_in_cmd = 1'b1;
							end
						end
					end else begin
						next_cnt = cnt_inc;
					end
				end
			end
			ST_TX: begin
				next_cnt = cnt_inc;
				if (!tx_bit) begin
					// Zero: held low, then a one-tick high kick before release
					next_oe = (next_cnt <= TX0_LOW_TICKS); // RL16
					next_out = (next_cnt == TX0_LOW_TICKS); // RL16
				end else begin
					// One: only a short drive high, after the host has let go
					next_oe = (next_cnt == TX1_PULSE_TICK); // RL14
					next_out = 1'b1; // RL14
				end
				if ((!tx_bit && next_cnt == TX0_LOW_TICKS + 8'h01)
					|| (tx_bit && next_cnt == TX1_PULSE_TICK + 8'h01)) begin
					next_state = ST_IDLE;
					next_bit_idx = bit_idx + 3'h1;
					next_low_cnt = 8'h00;
					if (bit_idx == 3'h7) begin
						next_tx_active = 1'b0;
					end
				end
			end
			ST_SYNC_WAIT_HIGH: begin
				next_cnt = 8'h00;
				if (wire_s) begin
					next_state = ST_SYNC_DELAY; // RL22
				end
			end
			ST_SYNC_DELAY: begin
				// Let the host finish its own high kick before we pull low
				next_cnt = cnt_inc;
				if (next_cnt == SYNC_DELAY_TICKS) begin
					next_state = ST_SYNC_LOW; // RL22
					next_cnt = 8'h00;
					next_oe = 1'b1;
				end
			end
			ST_SYNC_LOW: begin
				next_cnt = cnt_inc;
				next_oe = 1'b1;
				if (next_cnt == SYNC_LOW_TICKS) begin
					next_state = ST_SYNC_PULSE; // RL22
					next_out = 1'b1;
				end
			end
			ST_SYNC_PULSE: begin
				next_oe = !tick;
				next_out = 1'b1;
				if (tick) begin
					next_state = ST_IDLE;
					next_low_cnt = 8'h00;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Register stage; every top output below is a flop
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			cnt <= 8'h00;
			low_cnt <= 8'h00;
			tmo <= 10'h000;
			shreg <= '0;
			bit_idx <= 3'h0;
			in_cmd <= 1'b0;
			tx_active <= 1'b0;
			tx_bit <= 1'b0;
			debug_wire_pin_oe <= 1'b0;
			debug_wire_pin_out <= 1'b0;
			rx_valid <= 1'b0;
			rx_byte <= '0;
			cmd_rejected <= 1'b0;
			cmd_abort <= 1'b0;
			start_halted <= 1'b0;
			pull_up_en <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			low_cnt <= next_low_cnt;
			tmo <= next_tmo;
			shreg <= next_shreg;
			bit_idx <= next_bit_idx;
			in_cmd <= next_in_cmd;
			tx_active <= next_tx_active;
			tx_bit <= next_tx_bit;
			debug_wire_pin_oe <= next_oe; // RL17
			debug_wire_pin_out <= next_out;
			rx_valid <= next_rx_valid;
			rx_byte <= next_rx_byte;
			cmd_rejected <= next_rejected;
			cmd_abort <= next_abort;
			start_halted <= next_start_halted;
			// Internal pull-up keeps the idle wire high with no board resistor
			pull_up_en <= 1'b1; // RL17
		end
	end
	// The engine decodes nothing into the memory map and owns no peripheral RL3

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_tx0_drive;
		(debug_wire_pin_oe && !debug_wire_pin_out) [*8] ##5
		(debug_wire_pin_oe && !debug_wire_pin_out) ##1
		(debug_wire_pin_oe && debug_wire_pin_out);
	endsequence

	sequence s_tx1_drive;
		!debug_wire_pin_oe [*7] ##1 (debug_wire_pin_oe && debug_wire_pin_out);
	endsequence

	property p_rx_released;
		(state == ST_RX) |-> !debug_wire_pin_oe;
	endproperty
	a_rx_released: assert property (p_rx_released) else $error("wire driven in host bit"); // RL12

	property p_rx_sample;
		(start_tx == 1'b0 && state == ST_IDLE && fall && !debug_clock_source_select)
		|=> (state == ST_RX) [*8] ##1 (state == ST_RX) [*2] ##1 (state == ST_IDLE);
	endproperty
	a_rx_sample: assert property (p_rx_sample) else $error("host bit not sampled at ten"); // RL11

	property p_tx0;
		(start_tx0 && !debug_clock_source_select) |=> s_tx0_drive ##1 !debug_wire_pin_oe;
	endproperty
	a_tx0: assert property (p_tx0) else $error("zero reply shape wrong"); // RL16

	property p_tx1;
		(start_tx1 && !debug_clock_source_select) |=> s_tx1_drive ##1 !debug_wire_pin_oe;
	endproperty
	a_tx1: assert property (p_tx1) else $error("one reply pulse misplaced"); // RL14

	property p_timeout;
		timeout_hit |=> cmd_abort && (bit_idx == 3'h0) && !in_cmd && !rx_valid;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not abort"); // RL7

	property p_abort_quiet;
		cmd_abort |-> !rx_valid && !debug_wire_pin_oe;
	endproperty
	a_abort_quiet: assert property (p_abort_quiet) else $error("abort delivered data"); // RL8

	property p_reject;
		cmd_rejected |-> !rx_valid && !$past(cpu_halted) && !rx_byte.data[ACTIVE_GROUP_BIT];
	endproperty
	a_reject: assert property (p_reject) else $error("bad command refusal"); // RL1

	property p_sync_low;
		(state == ST_SYNC_LOW) && $past(state == ST_SYNC_LOW)
		|-> debug_wire_pin_oe && !debug_wire_pin_out;
	endproperty
	a_sync_low: assert property (p_sync_low) else $error("probe answer not low"); // RL22

	property p_sync_len;
		$rose(state == ST_SYNC_PULSE) |-> ($past(cnt) == SYNC_LOW_TICKS - 8'h01)
		&& debug_wire_pin_oe && debug_wire_pin_out;
	endproperty
	a_sync_len: assert property (p_sync_len) else $error("probe low length wrong"); // RL22

	property p_boot_mode;
		(!rst_s && wire_s) |=> !start_halted;
	endproperty
	a_boot_mode: assert property (p_boot_mode) else $error("pulled-up wire chose halt"); // RL18

endmodule

// ### verification/sdl_host.sv
// Debug pod model: starts every bit, sends host bits, reads replies, issues rate probes
`timescale 1ns/10ps
module sdl_host (
	input wire logic clock,
	input wire logic wire_lvl,
	output logic host_oe,
	output logic host_out
);
	int k = 1; // Clocks per debug tick
	initial begin
		host_oe = 1'b0;
		host_out = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Short low for a one, long low for a zero, then a speed-up pulse and release
	task automatic send_bit(input logic b);
		host_oe = 1'b1;
		host_out = 1'b0;
		wt((b ? 3 : 14) * k);
		host_out = 1'b1;
		wt(1);
		host_oe = 1'b0;
		wt((b ? 16 : 6) * k);
	endtask
	// Release early so the target pulse never fights the pod
	task automatic read_bit(output logic b);
		host_oe = 1'b1;
		host_out = 1'b0;
		wt(3 * k);
		host_oe = 1'b0;
		wt(7 * k);
		b = wire_lvl;
		wt(12 * k);
	endtask
	task automatic send_byte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) send_bit(d[i]);
	endtask
	task automatic read_byte(output logic [7:0] d);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			read_bit(b);
			d[i] = b;
		end
	endtask
	// Long low, speed-up, release; measure the gap and the answer's low time
	task automatic probe(input int low_clk, output int gap, output int resp);
		host_oe = 1'b1;
		host_out = 1'b0;
		wt(low_clk);
		host_out = 1'b1;
		wt(1);
		host_oe = 1'b0;
		gap = 0;
		while (wire_lvl === 1'b1 && gap < 2000) begin
			wt(1);
			gap++;
		end
		resp = 0;
		while (wire_lvl === 1'b0 && resp < 2000) begin
			wt(1);
			resp++;
		end
		wt(20 * k);
	endtask
endmodule

// ### verification/single_wire_debug_link_tb.sv
// Testbench of the single-wire debug link engine against a pod model
`timescale 1ns/10ps
module single_wire_debug_link_tb;
	import sdl_pkg::*;
	logic clock = 0, arst_n = 0, sel = 0, alt_tick = 0, pin, link_out, link_oe, pull_up_en;
	logic sys_reset_n = 1, start_halted, cpu_halted = 0, cmd_end = 0, rx_valid;
	logic cmd_rejected, cmd_abort, tx_valid = 0, tx_ready, host_oe, host_out;
	logic [CMD_W-1:0] tx_data = 8'h00;
	logic [7:0] v [FIFO_DEPTH];
	logic [7:0] d;
	logic host_sending = 0;
	logic [31:0] seed = 32'ha93f31c0;
	sdl_rx_byte_t rx_byte;
	sdl_rx_byte_t rxq [$];
	int err_total = 0, comparisons = 0, n_rej = 0, n_abort = 0, oe_in_rx = 0, oe_cnt = 0;
	int gap, resp, ones;

	// Pad: target drive wins, then pod, else the internal pull-up holds it high
	assign pin = link_oe ? link_out : (host_oe ? host_out : 1'b1);

	initial begin
		forever #2 clock = ~clock;
	end
	// Alternate debug clock: one enable every second clock
	always @(posedge clock) alt_tick <= sel ? ~alt_tick : 1'b0;

	sdl_link sdl_link_inst (.clock(clock), .arst_n(arst_n), .debug_clock_source_select(sel),
		.alt_tick(alt_tick), .debug_wire_pin_in(pin), .debug_wire_pin_out(link_out),
		.debug_wire_pin_oe(link_oe), .pull_up_en(pull_up_en), .sys_reset_n(sys_reset_n),
		.start_halted(start_halted), .cpu_halted(cpu_halted), .cmd_end(cmd_end),
		.rx_valid(rx_valid), .rx_byte(rx_byte), .cmd_rejected(cmd_rejected),
		.cmd_abort(cmd_abort), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
	sdl_host sdl_host_inst (.clock(clock), .wire_lvl(pin), .host_oe(host_oe),
		.host_out(host_out));

	// Monitor: collects bytes and pulses as the bench model's observed side
	always @(posedge clock) begin
		if (rx_valid === 1'b1) rxq.push_back(rx_byte);
		if (cmd_rejected === 1'b1) n_rej++;
		if (cmd_abort === 1'b1) n_abort++;
		if (link_oe === 1'b1) oe_cnt++;
		if (host_sending && link_oe !== 1'b0) oe_in_rx++;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic end_sim();
		$display("Comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check_vec(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic check_num(input string nm, input int e, input int g);
		comparisons++;
		if (g != e) begin
			err_total++;
			$display("BAD %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic check_rx(input sdl_rx_byte_t e);
		sdl_rx_byte_t g;
		g = 'x;
		if (rxq.size() > 0) g = rxq.pop_front();
		check_vec("rx_byte", 16'(e), 16'(g));
	endtask
	task automatic do_reset();
		arst_n = 1'b0;
		step(12);
		check_vec("oe_in_reset", 0, link_oe);
		check_vec("pull_up_in_reset", 0, pull_up_en);
		check_vec("tx_ready_in_reset", 1, tx_ready);
		arst_n = 1'b1;
		step(3);
		check_vec("pull_up", 1, pull_up_en);
	endtask
	// One command: code byte, then one data byte if the code is accepted
	task automatic do_cmd(input logic [7:0] code, input logic [7:0] dat, input logic halted);
		logic rej;
		rej = !code[ACTIVE_GROUP_BIT] && !halted;
		cpu_halted = halted;
		n_rej = 0;
		host_sending = 1;
		sdl_host_inst.send_byte(code);
		check_num("rejected", rej, n_rej);
		if (!rej) begin
			check_rx('{1'b1, code});
			sdl_host_inst.send_byte(dat);
			check_rx('{1'b0, dat});
		end
		host_sending = 0;
		cmd_end = 1'b1;
		step(1);
		cmd_end = 1'b0;
		step(1);
	endtask
	task automatic push(input logic [7:0] x);
		int n;
		n = 0;
		tx_valid = 1'b1;
		tx_data = x;
		// Ready is a flop, so its value just after an edge is what the next edge sees
		while (tx_ready !== 1'b1 && n < 50) begin
			step(1);
			n++;
		end
		step(1);
		tx_valid = 1'b0;
		if (n >= 50) begin
			err_total++;
			end_sim();
		end
		step(1);
	endtask

	initial begin
		#300000;
		err_total++;
		$display("BAD watchdog expected end seen hang");
		end_sim();
	end

	initial begin
		step(1);
		do_reset();
		// Start mode follows the wire while system reset is held
		sys_reset_n = 1'b0;
		sdl_host_inst.host_oe = 1'b1;
		sdl_host_inst.host_out = 1'b0;
		step(6);
		check_vec("start_halted_low", 1, start_halted);
		sdl_host_inst.host_oe = 1'b0;
		step(6);
		check_vec("start_halted_pulled", 0, start_halted);
		sdl_host_inst.host_oe = 1'b1;
		step(6);
		sys_reset_n = 1'b1;
		step(6);
		sdl_host_inst.host_oe = 1'b0;
		step(6);
		check_vec("start_halted_hold", 1, start_halted);
		do_reset();
		rxq.delete();
		$display("test reset done");
		// Random commands, first two forced into both halted-only outcomes
		for (int i = 0; i < 6; i++) begin
			logic [31:0] r;
			r = rnd();
			do_cmd({(i < 2) ? 1'b0 : r[7], r[6:0]}, r[15:8], (i == 0) ? 1'b0 : (i == 1) | r[16]);
		end
		check_num("oe_during_host_bits", 0, oe_in_rx);
		$display("test commands done");
		// Fill the reply buffer until it refuses, then drain it over the wire
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			v[i] = 8'(rnd());
			push(v[i]);
		end
		step(1);
		check_vec("tx_ready_full", 0, tx_ready);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			oe_cnt = 0;
			ones = $countones(v[i]);
			sdl_host_inst.read_byte(d);
			check_vec("reply", v[i], d);
			check_num("reply_drive", ones + (8 - ones) * 14, oe_cnt);
		end
		check_vec("tx_ready_empty", 1, tx_ready);
		$display("test replies done");
		// Stall inside a byte of an open command
		cpu_halted = 1'b1;
		sdl_host_inst.send_byte(8'h6c);
		check_rx('{1'b1, 8'h6c});
		sdl_host_inst.send_bit(1'b1);
		sdl_host_inst.send_bit(1'b0);
		sdl_host_inst.send_bit(1'b1);
		n_abort = 0;
		step(480);
		check_num("abort_early", 0, n_abort);
		step(40);
		check_num("abort", 1, n_abort);
		check_num("rx_partial", 0, rxq.size());
		do_cmd(8'he0, 8'h5a, 1'b0);
		$display("test timeout done");
		// Rate probe on the bus clock and on the alternate clock
		for (int m = 1; m <= 2; m++) begin
			sel = (m == 2);
			sdl_host_inst.k = m;
			step(4);
			sdl_host_inst.send_byte(8'he4);
			check_rx('{1'b1, 8'he4});
			n_abort = 0;
			sdl_host_inst.probe(160 * m, gap, resp);
			check_num("probe_abort", 1, n_abort);
			check_num("probe_low", 128 * m, resp);
			check_num("probe_gap_ok", 1, gap >= 16 * m && gap <= 16 * m + 5);
			do_cmd(8'h88, 8'ha5, 1'b0);
		end
		check_num("rx_left", 0, rxq.size());
		$display("test probe done");
		end_sim();
	end
endmodule
